// file: ocd_consts.vh
`ifndef OCD_CONSTS_VH
`define OCD_CONSTS_VH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define OCD_ADDR_W 10
`define OCD_OFS_DIV_CTRL 10'h19a
`define OCD_OFS_PWR_ROUTE 10'h19b
`define OCD_OFS_FRONT_RATIO 10'h1e0
`define OCD_OFS_FRONT_SRC 10'h1e1

// ----------------------------------------
// field positions
// ----------------------------------------
`define OCD_BIT_BYPASS 7
`define OCD_BIT_IGN_SYNC 6
`define OCD_BIT_FORCE 5
`define OCD_BIT_START_HIGH 4
`define OCD_PHASE_MSB 3
`define OCD_PHASE_LSB 0
`define OCD_BIT_PWR_DOWN 2
`define OCD_BIT_DIRECT 1
`define OCD_BIT_DCC_DIS 0
`define OCD_RATIO_MSB 2
`define OCD_RATIO_LSB 0
`define OCD_BIT_SEL_OSC 1
`define OCD_BIT_FRONT_BYP 0

// ----------------------------------------
// reset values
// ----------------------------------------
`define OCD_RST_DIV_CTRL 8'h00
`define OCD_RST_PWR_ROUTE 3'h0
`define OCD_RST_FRONT_RATIO 3'h0
`define OCD_RST_FRONT_SRC 2'h0

// ----------------------------------------
// source select codes, front ratio bias
// ----------------------------------------
`define OCD_SRC_OSC 2'h2
`define OCD_SRC_EXT 2'h0
`define OCD_SRC_NONE 2'h1
`define OCD_RATIO_BIAS 4'h2
`define OCD_RATIO_MAX_CODE 3'h4

// ----------------------------------------
// timing
// ----------------------------------------
`define OCD_SYNC_STAGES 2

`endif

// file: ocd_chan_div.v
`timescale 1ns/100ps
`include "ocd_consts.vh"

module ocd_chan_div #(
  parameter [3:0] LOW_CYC = 4'h0,
  parameter [3:0] HIGH_CYC = 4'h0
) (
  input wire clk_sys_i,
  input wire rst_n_i,
  input wire ce_i,
  input wire in_lvl_i,
  input wire in_rise_i,
  input wire bypass_i,
  input wire ignore_sync_i,
  input wire force_i,
  input wire start_high_i,
  input wire [3:0] phase_i,
  input wire dcc_dis_i,
  input wire sync_i,
  output wire div_o,
  output wire running_o
);

  // ----------------------------------------
  // states
  // ----------------------------------------
  localparam [1:0] ST_HOLD = 2'h0;
  localparam [1:0] ST_DELAY = 2'h1;
  localparam [1:0] ST_RUN = 2'h2;

  reg [1:0] state_ff;
  reg [1:0] nxt_state;
  reg [4:0] cnt_ff;
  reg [4:0] nxt_cnt;
  reg lvl_ff;
  reg nxt_lvl;
  reg out_ff;
  reg nxt_out;
  wire sync_eff;
  wire [5:0] period;
  wire [4:0] dcc_hi;
  wire [4:0] dcc_lo;
  wire [5:0] lo_full;
  wire [4:0] hi_len;
  wire [4:0] lo_len;
  wire [4:0] cur_len;

  assign sync_eff = sync_i & ~ignore_sync_i;
  assign period = {2'h0, HIGH_CYC} + {2'h0, LOW_CYC} + 6'h02;
  // integer split; odd periods differ by one input cycle
  assign dcc_hi = period[5:1] - 5'h01;
  assign lo_full = period - {1'b0, period[5:1]} - 6'h01;
  assign dcc_lo = lo_full[4:0];
  assign hi_len = dcc_dis_i ? {1'b0, HIGH_CYC} : dcc_hi;
  assign lo_len = dcc_dis_i ? {1'b0, LOW_CYC} : dcc_lo;
  assign cur_len = lvl_ff ? hi_len : lo_len;

  // ----------------------------------------
  // divider sequence
  // ----------------------------------------
  always @*
  begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_lvl = lvl_ff;
    if (bypass_i || sync_eff)
    begin
      // bypass powers the divider down; sync holds it at start level
      nxt_state = ST_HOLD;
      nxt_cnt = 5'h00;
      nxt_lvl = start_high_i;
    end
    else
    begin
      case (state_ff)
        ST_HOLD:
        begin
          nxt_cnt = 5'h00;
          nxt_lvl = start_high_i;
          nxt_state = (phase_i == 4'h0) ? ST_RUN : ST_DELAY;
        end
        ST_DELAY:
        begin
          if (in_rise_i)
          begin
            // a shortened offset ends the wait at the next input rise
            if (cnt_ff[3:0] + 4'h1 >= phase_i)
            begin
              nxt_state = ST_RUN;
              nxt_cnt = 5'h00;
            end
            else
            begin
              nxt_cnt = cnt_ff + 5'h01;
            end
          end
        end
        ST_RUN:
        begin
          if (in_rise_i)
          begin
            if (cnt_ff >= cur_len)
            begin
              nxt_cnt = 5'h00;
              nxt_lvl = ~lvl_ff;
            end
            else
            begin
              nxt_cnt = cnt_ff + 5'h01;
            end
          end
        end
        default:
        begin
          nxt_state = ST_HOLD;
          nxt_cnt = 5'h00;
        end
      endcase
    end
  end

  // ----------------------------------------
  // output select
  // ----------------------------------------
  always @*
  begin
    if (bypass_i)
    begin
      nxt_out = in_lvl_i;
    end
    else if (ignore_sync_i && sync_i)
    begin
      nxt_out = force_i & start_high_i;
    end
    else
    begin
      nxt_out = lvl_ff;
    end
  end

  always @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      state_ff <= ST_HOLD;
      cnt_ff <= 5'h00;
      lvl_ff <= 1'b0;
      out_ff <= 1'b0;
    end
    else if (ce_i)
    begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      lvl_ff <= nxt_lvl;
      out_ff <= nxt_out;
    end
  end

  assign div_o = out_ff;
  assign running_o = (state_ff == ST_RUN);

endmodule

// file: ocd_top.v
// What this block does
// - bypass passes input through, divider powered down
// - ignore-sync bit makes divider disregard sync
// - forced output static at start-high level while ignore-sync bit set and sync asserted
// - force ignored while divider bypassed
// - start-level bit picks initial divider level
// - four-bit phase offset, reset zero
// - power-down puts all three outputs safe
// - direct route picks oscillator or external clock; source select 01 keeps divider output
// - duty-cycle fix unless disable bit set
// - front divider ratio two to six
// - source select; oscillator forbids front bypass
// - front bypass; forbids oscillator selection
`timescale 1ns/100ps
`include "ocd_consts.vh"

module ocd_top #(
  parameter [3:0] CH_LOW_CYC = 4'h0,
  parameter [3:0] CH_HIGH_CYC = 4'h0
) (
  input wire clk_sys_i,
  input wire rst_n_i,
  input wire ce_i,
  input wire [9:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  output wire [7:0] reg_rdata_o,
  output wire reg_rvalid_o,
  input wire ext_clk_i,
  input wire internal_oscillator_i,
  input wire sync_n_i,
  output wire group3_output_a_o,
  output wire group3_output_b_o,
  output wire group3_output_c_o,
  output wire group3_pd_o,
  output wire duty_cycle_fix_o,
  output wire front_div_o,
  output wire div_running_o
);

  // ----------------------------------------
  // registers
  // ----------------------------------------
  reg [7:0] div_ctrl_ff;
  reg [2:0] pwr_route_ff;
  reg [2:0] front_ratio_ff;
  reg [1:0] front_src_ff;
  reg [7:0] rdata_ff;
  reg [7:0] nxt_rdata;
  reg rvalid_ff;
  reg [1:0] nxt_src;

  always @*
  begin
    nxt_src = front_src_ff;
    if (reg_wr_i && reg_addr_i == `OCD_OFS_FRONT_SRC)
    begin
      nxt_src = reg_wdata_i[1:0];
      // a request for both is refused as a whole; the old setting stays
      if (reg_wdata_i[`OCD_BIT_SEL_OSC] && reg_wdata_i[`OCD_BIT_FRONT_BYP])
      begin
        nxt_src = front_src_ff;
      end
    end
  end

  always @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      div_ctrl_ff <= `OCD_RST_DIV_CTRL;
      pwr_route_ff <= `OCD_RST_PWR_ROUTE;
      front_ratio_ff <= `OCD_RST_FRONT_RATIO;
      front_src_ff <= `OCD_RST_FRONT_SRC;
    end
    else if (ce_i)
    begin
      if (reg_wr_i && reg_addr_i == `OCD_OFS_DIV_CTRL)
      begin
        div_ctrl_ff <= reg_wdata_i;
      end
      if (reg_wr_i && reg_addr_i == `OCD_OFS_PWR_ROUTE)
      begin
        pwr_route_ff <= reg_wdata_i[2:0];
      end
      if (reg_wr_i && reg_addr_i == `OCD_OFS_FRONT_RATIO)
      begin
        front_ratio_ff <= reg_wdata_i[`OCD_RATIO_MSB:`OCD_RATIO_LSB];
      end
      front_src_ff <= nxt_src;
    end
  end

  // ----------------------------------------
  // readback
  // ----------------------------------------
  always @*
  begin
    // reserved bits read back as zero
    case (reg_addr_i)
      `OCD_OFS_DIV_CTRL: nxt_rdata = div_ctrl_ff;
      `OCD_OFS_PWR_ROUTE: nxt_rdata = {5'h00, pwr_route_ff};
      `OCD_OFS_FRONT_RATIO: nxt_rdata = {5'h00, front_ratio_ff};
      `OCD_OFS_FRONT_SRC: nxt_rdata = {6'h00, front_src_ff};
      default: nxt_rdata = 8'h00;
    endcase
  end

  always @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      rdata_ff <= 8'h00;
      rvalid_ff <= 1'b0;
    end
    else if (ce_i)
    begin
      rvalid_ff <= reg_rd_i;
      if (reg_rd_i)
      begin
        rdata_ff <= nxt_rdata;
      end
    end
  end

  assign reg_rdata_o = rdata_ff;
  assign reg_rvalid_o = rvalid_ff;

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  wire [2:0] pin_raw;
  wire [2:0] pin_sync;
  wire [2:0] pin_rise;
  assign pin_raw = {~sync_n_i, internal_oscillator_i, ext_clk_i};

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1)
    begin : g_pin
      reg meta_ff;
      reg sync_ff;
      reg last_ff;
      always @(posedge clk_sys_i)
      begin
        if (!rst_n_i)
        begin
          meta_ff <= 1'b0;
          sync_ff <= 1'b0;
          last_ff <= 1'b0;
        end
        else if (ce_i)
        begin
          meta_ff <= pin_raw[gi];
          sync_ff <= meta_ff;
          last_ff <= sync_ff;
        end
      end
      assign pin_sync[gi] = sync_ff;
      // edge taken from the second and third stages; meta_ff feeds nothing else
      assign pin_rise[gi] = sync_ff & ~last_ff;
    end
  endgenerate

  wire ext_lvl;
  wire osc_lvl;
  wire chip_sync;
  assign ext_lvl = pin_sync[0];
  assign osc_lvl = pin_sync[1];
  assign chip_sync = pin_sync[2];

  // ----------------------------------------
  // front-end divider
  // ----------------------------------------
  wire sel_osc;
  wire front_byp;
  wire src_lvl;
  wire src_rise;
  wire [2:0] ratio_code;
  wire [3:0] ratio;
  wire [3:0] half;
  reg [3:0] fcnt_ff;
  reg [3:0] nxt_fcnt;
  reg flvl_ff;
  reg flast_ff;

  assign sel_osc = front_src_ff[`OCD_BIT_SEL_OSC];
  assign front_byp = front_src_ff[`OCD_BIT_FRONT_BYP] & ~sel_osc;
  assign src_lvl = sel_osc ? osc_lvl : ext_lvl;
  assign src_rise = sel_osc ? pin_rise[1] : pin_rise[0];
  // codes above the table fall back to the largest ratio
  assign ratio_code = (front_ratio_ff > `OCD_RATIO_MAX_CODE) ? `OCD_RATIO_MAX_CODE : front_ratio_ff;
  assign ratio = {1'b0, ratio_code} + `OCD_RATIO_BIAS;
  assign half = {1'b0, ratio[3:1]} + {3'h0, ratio[0]};

  always @*
  begin
    nxt_fcnt = fcnt_ff;
    if (src_rise)
    begin
      if (fcnt_ff >= ratio - 4'h1)
      begin
        nxt_fcnt = 4'h0;
      end
      else
      begin
        nxt_fcnt = fcnt_ff + 4'h1;
      end
    end
  end

  always @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      fcnt_ff <= 4'h0;
      flvl_ff <= 1'b0;
      flast_ff <= 1'b0;
    end
    else if (ce_i)
    begin
      fcnt_ff <= front_byp ? 4'h0 : nxt_fcnt;
      flvl_ff <= front_byp ? src_lvl : (nxt_fcnt < half);
      flast_ff <= flvl_ff;
    end
  end

  wire ch_in_lvl;
  wire ch_in_rise;
  assign ch_in_lvl = flvl_ff;
  // channel divider counts front-divider rising edges
  assign ch_in_rise = flvl_ff & ~flast_ff;
  assign front_div_o = flvl_ff;

  // ----------------------------------------
  // channel divider
  // ----------------------------------------
  wire div_out;

  ocd_chan_div #(
    .LOW_CYC(CH_LOW_CYC),
    .HIGH_CYC(CH_HIGH_CYC)
  ) u_chan_div (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .in_lvl_i(ch_in_lvl),
    .in_rise_i(ch_in_rise),
    .bypass_i(div_ctrl_ff[`OCD_BIT_BYPASS]),
    .ignore_sync_i(div_ctrl_ff[`OCD_BIT_IGN_SYNC]),
    .force_i(div_ctrl_ff[`OCD_BIT_FORCE]),
    .start_high_i(div_ctrl_ff[`OCD_BIT_START_HIGH]),
    .phase_i(div_ctrl_ff[`OCD_PHASE_MSB:`OCD_PHASE_LSB]),
    .dcc_dis_i(pwr_route_ff[`OCD_BIT_DCC_DIS]),
    .sync_i(chip_sync),
    .div_o(div_out),
    .running_o(div_running_o)
  );

  // ----------------------------------------
  // group output routing
  // ----------------------------------------
  reg grp_ff;
  reg nxt_grp;

  always @*
  begin
    nxt_grp = div_out;
    if (pwr_route_ff[`OCD_BIT_PWR_DOWN])
    begin
      // safe state is a steady low on all three outputs
      nxt_grp = 1'b0;
    end
    else if (pwr_route_ff[`OCD_BIT_DIRECT])
    begin
      case (front_src_ff)
        `OCD_SRC_OSC: nxt_grp = osc_lvl;
        `OCD_SRC_EXT: nxt_grp = ext_lvl;
        default: nxt_grp = div_out;
      endcase
    end
  end

  always @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      grp_ff <= 1'b0;
    end
    else if (ce_i)
    begin
      grp_ff <= nxt_grp;
    end
  end

  // one flop feeds all three outputs, so they cannot skew
  assign group3_output_a_o = grp_ff;
  assign group3_output_b_o = grp_ff;
  assign group3_output_c_o = grp_ff;
  assign group3_pd_o = pwr_route_ff[`OCD_BIT_PWR_DOWN];
  assign duty_cycle_fix_o = ~pwr_route_ff[`OCD_BIT_DCC_DIS];

endmodule

// file: ocd_top_props.sv
`timescale 1ns/100ps
module ocd_top_props (
  input wire clk_sys_i,
  input wire rst_n_i,
  input wire ce_i,
  input wire [9:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  input wire [7:0] reg_rdata_o,
  input wire reg_rvalid_o,
  input wire group3_output_a_o,
  input wire group3_output_b_o,
  input wire group3_output_c_o,
  input wire group3_pd_o,
  input wire duty_cycle_fix_o,
  input wire front_div_o
);
  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_rd_taken;
    reg_rd_i && ce_i;
  endsequence
  sequence s_route_wr;
    reg_wr_i && ce_i && reg_addr_i == 10'h19b;
  endsequence
  a_read_answered: assert property (s_rd_taken |=> reg_rvalid_o)
    else $error("read strobe not answered");
  a_answer_has_cause: assert property (reg_rvalid_o && $past(ce_i) |-> $past(reg_rd_i))
    else $error("read valid without read strobe");
  a_rdata_holds: assert property (!reg_rvalid_o |-> $stable(reg_rdata_o))
    else $error("read data moved without read");
  a_unmapped_zero: assert property (s_rd_taken ##0 (reg_addr_i != 10'h19a && reg_addr_i != 10'h19b
    && reg_addr_i != 10'h1e0 && reg_addr_i != 10'h1e1) |=> reg_rdata_o == 8'h00)
    else $error("unmapped read not zero");
  a_pd_write: assert property (s_route_wr |=> group3_pd_o == $past(reg_wdata_i[2]))
    else $error("power-down bit not applied");
  a_dcc_write: assert property (s_route_wr |=> duty_cycle_fix_o == !$past(reg_wdata_i[0]))
    else $error("duty fix enable not applied");
  a_group_equal: assert property (group3_output_a_o == group3_output_b_o
    && group3_output_b_o == group3_output_c_o)
    else $error("group outputs differ");
  a_pd_quiet: assert property (group3_pd_o [*3] |-> !group3_output_a_o)
    else $error("output active while powered down");
  a_ce_freeze: assert property ($past(!ce_i) |-> $stable(front_div_o) && $stable(group3_output_a_o))
    else $error("clock outputs moved while frozen");
endmodule
bind ocd_top ocd_top_props u_props (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
  .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o), .group3_output_a_o(group3_output_a_o),
  .group3_output_b_o(group3_output_b_o), .group3_output_c_o(group3_output_c_o),
  .group3_pd_o(group3_pd_o), .duty_cycle_fix_o(duty_cycle_fix_o), .front_div_o(front_div_o));

// file: test_ocd_top.sv
`timescale 1ns/100ps
module test_ocd_top;
  reg clk_sys_i = 1'b0;
  reg rst_n_i = 1'b0;
  reg ce_i = 1'b1;
  reg [9:0] reg_addr_i = 10'h000;
  reg [7:0] reg_wdata_i = 8'h00;
  reg reg_wr_i = 1'b0;
  reg reg_rd_i = 1'b0;
  reg ext_clk_i = 1'b0;
  reg osc_i = 1'b0;
  reg sync_n_i = 1'b1;
  wire [7:0] reg_rdata_o;
  wire rvalid, g_a, g_b, g_c, pd, dcc, front, run;
  integer errors = 0;
  integer cmp_count = 0;
  integer fr, gr, i, k;
  reg pf, pg, exp_lvl;
  reg [31:0] seed = 32'h154be;
  reg [7:0] d;
  reg [19:0] r;

  always #5 clk_sys_i = ~clk_sys_i;

  ocd_top uut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .reg_rvalid_o(rvalid), .ext_clk_i(ext_clk_i), .internal_oscillator_i(osc_i), .sync_n_i(sync_n_i),
    .group3_output_a_o(g_a), .group3_output_b_o(g_b), .group3_output_c_o(g_c), .group3_pd_o(pd),
    .duty_cycle_fix_o(dcc), .front_div_o(front), .div_running_o(run));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function [31:0] xs(input [31:0] x);
    reg [31:0] y;
    begin
      y = x ^ (x << 13);
      y = y ^ (y >> 17);
      xs = y ^ (y << 5);
    end
  endfunction

  // cfg, sync pin level, group rises in 16 periods, static level
  function [19:0] row(input integer n);
    begin
      case (n)
        0: row = 20'h00140;
        1: row = 20'h80180;
        2: row = 20'hf0080;
        3: row = 20'h70001;
        4: row = 20'h50000;
        5: row = 20'h10001;
        default: row = 20'h14140;
      endcase
    end
  endfunction

  // divider runs unless bypassed or held by an obeyed sync
  function exp_run(input [7:0] cfg, input sn);
    begin
      exp_run = ~cfg[7] & (sn | cfg[6]);
    end
  endfunction

  task chk(input [7:0] got, input [7:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (got !== exp)
      begin
        errors = errors + 1;
        $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask

  task wr(input [9:0] a, input [7:0] v);
    begin
      @(negedge clk_sys_i);
      reg_addr_i = a;
      reg_wdata_i = v;
      reg_wr_i = 1'b1;
      @(negedge clk_sys_i);
      reg_wr_i = 1'b0;
    end
  endtask

  task rd(input [9:0] a, input [7:0] exp);
    begin
      @(negedge clk_sys_i);
      reg_addr_i = a;
      reg_rd_i = 1'b1;
      @(negedge clk_sys_i);
      reg_rd_i = 1'b0;
      chk({7'h00, rvalid}, 8'h01);
      chk(reg_rdata_o, exp);
    end
  endtask

  // ext pin period is 8 system cycles, slow enough for the synchronisers
  task spin(input integer np);
    integer j;
    begin
      fr = 0;
      gr = 0;
      pf = front;
      pg = g_a;
      for (j = 0; j < np * 8; j = j + 1)
      begin
        @(negedge clk_sys_i);
        if (j % 4 == 0) ext_clk_i = ~ext_clk_i;
        if (front && !pf) fr = fr + 1;
        if (g_a && !pg) gr = gr + 1;
        pf = front;
        pg = g_a;
      end
    end
  endtask

  task tally_and_finish;
    begin
      $display("comparisons %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask

  initial
  begin
    #500000;
    errors = errors + 1;
    tally_and_finish;
  end

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial
  begin
    repeat (5) @(negedge clk_sys_i);
    rst_n_i = 1'b1;
    chk({7'h00, dcc}, 8'h01);
    rd(10'h19a, 8'h00);
    rd(10'h19b, 8'h00);
    rd(10'h1e0, 8'h00);
    rd(10'h1e1, 8'h00);
    for (i = 0; i < 12; i = i + 1)
    begin
      seed = xs(seed);
      d = (i == 0) ? 8'hff : seed[7:0];
      wr(10'h19a, d);
      wr(10'h19b, d);
      wr(10'h1e0, d);
      wr(10'h3ff, d);
      chk({7'h00, pd}, {7'h00, d[2]});
      chk({7'h00, dcc}, {7'h00, ~d[0]});
      rd(10'h19a, d);
      rd(10'h19b, d & 8'h07);
      rd(10'h1e0, d & 8'h07);
      rd(10'h3ff, 8'h00);
    end
    wr(10'h19b, 8'h00);
    wr(10'h1e0, 8'h00);
    for (k = 0; k < 7; k = k + 1)
    begin
      r = row(k);
      wr(10'h19a, r[19:12]);
      sync_n_i = r[8];
      repeat (4) @(negedge clk_sys_i);
      if (r[15:12] != 4'h0) chk({7'h00, run}, 8'h00);
      spin(12);
      spin(16);
      chk({7'h00, run}, {7'h00, exp_run(r[19:12], r[8])});
      chk(gr[7:0], {4'h0, r[7:4]});
      if (r[7:4] == 4'h0) chk({7'h00, g_a}, {7'h00, r[0]});
    end
    ce_i = 1'b0;
    spin(2);
    ce_i = 1'b1;
    for (k = 0; k < 5; k = k + 1)
    begin
      wr(10'h1e0, k[7:0]);
      spin(2 * (k + 2));
      spin(4 * (k + 2));
      chk(fr[7:0], 8'h04);
    end
    wr(10'h1e0, 8'h00);
    wr(10'h19b, 8'h05);
    spin(4);
    chk({gr[6:0], g_a}, 8'h00);
    wr(10'h19b, 8'h02);
    // select 01 must leave the forced divider level on the outputs
    wr(10'h19a, 8'h70);
    sync_n_i = 1'b0;
    for (k = 0; k < 3; k = k + 1)
    begin
      wr(10'h1e1, k[7:0]);
      for (i = 0; i < 4; i = i + 1)
      begin
        seed = xs(seed);
        ext_clk_i = seed[0];
        osc_i = seed[1];
        exp_lvl = (k == 2) ? osc_i : ((k == 1) ? 1'b1 : ext_clk_i);
        repeat (6) @(negedge clk_sys_i);
        chk({7'h00, g_a}, {7'h00, exp_lvl});
      end
    end
    wr(10'h1e1, 8'h03);
    rd(10'h1e1, 8'h02);
    wr(10'h1e1, 8'h01);
    wr(10'h1e1, 8'h03);
    rd(10'h1e1, 8'h01);
    tally_and_finish;
  end
endmodule
